/* File: hw/uart_status_map.svh */
// Register offsets, field positions and reset values of the serial port status block.
// Included by the package and the design; definitions only.
`ifndef UART_STATUS_MAP_SVH
`define UART_STATUS_MAP_SVH

`define ADDR_W 4
// Register word offsets (byte address = offset)
`define OFS_INT_RAW 4'h0
`define OFS_INT_MASKED 4'h1
`define OFS_INT_ENABLE 4'h2
`define OFS_INT_CLEAR 4'h3
`define OFS_MODEM_SET 4'h4
`define OFS_MODEM_CLR 4'h5
`define OFS_MODEM_OUT 4'h6
`define OFS_MODEM_IN 4'h7
`define OFS_PARITY 4'h8
`define OFS_RX_ERR 4'h9
`define OFS_RX_ERR_CLR 4'ha

// Interrupt source bit positions
`define IRQ_N 12
`define IRQ_ADDR_MATCH 0
`define IRQ_OVERRUN 1
`define IRQ_BREAK 2
`define IRQ_PARITY 3
`define IRQ_FRAMING 4
`define IRQ_RX_TIMEOUT 5
`define IRQ_TX 6
`define IRQ_RX 7
`define IRQ_DSR 8
`define IRQ_DCD 9
`define IRQ_CTS 10
`define IRQ_RI 11

// Modem output bits
`define MOUT_DTR 0
`define MOUT_RTS 1
// Modem input bits
`define MIN_RI 0
`define MIN_DCD 1
`define MIN_DSR 2
`define MIN_CTS 3

// Receive error bits
`define RXE_FRAMING 0
`define RXE_PARITY 1
`define RXE_BREAK 2
`define RXE_OVERRUN 3

`define RST_IRQ_EN 12'h000
`define RST_PARITY 3'h0

`endif

/* File: hw/uart_status_pkg.sv */
// Types of the serial port status block.
// Assumes uart_status_map.svh is on the include path.
`include "uart_status_map.svh"
package uart_status_pkg;

   typedef enum logic [2:0] {
      parity_off = 3'h0,
      parity_even_sel = 3'h1,
      parity_odd_sel = 3'h2,
      parity_stick_high = 3'h3,
      parity_stick_low = 3'h4
   } parity_mode_e;

   typedef struct packed {
      logic [`ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

   typedef struct packed {
      logic rx_char_valid;
      logic rx_framing;
      logic rx_parity_bad;
      logic rx_break;
      logic overrun;
   } rx_event_s;

   typedef struct packed {
      logic [`IRQ_N-1:0] raw;
      logic [`IRQ_N-1:0] enable;
      logic [1:0] modem_out;
      logic [3:0] modem_meta;
      logic [3:0] modem_in;
      logic [3:0] modem_prev;
      parity_mode_e parity;
      logic [3:0] rx_err;
      logic [31:0] rdata;
      logic irq;
   } state_s;

endpackage : uart_status_pkg

/* File: hw/uart_irq_modem_error_status.sv */
// Interrupt, modem handshake, parity mode and receive error status of a serial port.
// Assumes the framing/data engine on the same clock supplies event pulses and the
// received character's error bits, and that modem inputs arrive straight from pins.
//
// Functional notes
// - Per-source enable mask; a disabled source never raises the interrupt output.
// - Twelve sources: address match, overrun, break, parity, framing, timeout, tx, rx, modem.
// - Software reads raw status and masked status separately.
// - Clearing a set of sources drops exactly those latched status bits.
// - Setting DTR or RTS leaves the other handshake output unchanged.
// - Clearing DTR or RTS leaves the other handshake output unchanged.
// - Reading returns asserted state of DTR and RTS as separate flags.
// - RI, DCD, DSR, CTS inputs are sampled and readable as four flags.
// - One parity mode serves transmit insertion and receive checking.
// - Stick modes fix the parity bit; receive checks against that fixed level.
// - Error register holds framing, parity, break, overrun since last clear.
// - Framing, parity, break flags latch from each character as it is read.
// - Overrun flag sets in the cycle the overrun occurs.
// - One clear operation resets all four error flags.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "uart_status_map.svh"
module uart_irq_modem_error_status (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Events from the serial engine, same clock
   input wire logic addr_match_evt,
   input wire logic rx_timeout_evt,
   input wire logic tx_evt,
   input wire logic rx_evt,
   input wire logic rx_char_read,
   input wire logic rx_char_framing,
   input wire logic rx_char_parity,
   input wire logic rx_char_break,
   input wire logic overrun_evt,
   // Parity service to the serial engine
   input wire logic [7:0] tx_data,
   output logic tx_parity_en,
   output logic tx_parity_bit,
   input wire logic [7:0] rx_data,
   input wire logic rx_parity_in,
   output logic rx_parity_err,
   output uart_status_pkg::parity_mode_e parity_mode,
   // Modem pins
   input wire logic ring_in,
   input wire logic carrier_in,
   input wire logic dsr_in,
   input wire logic cts_in,
   output logic dtr_out,
   output logic rts_out,
   // Interrupt
   output logic irq
);

   uart_status_pkg::state_s st_reg;
   uart_status_pkg::state_s st_next;
   uart_status_pkg::bus_req_s req;
   logic [`IRQ_N-1:0] irq_set;
   logic [3:0] err_set;
   logic [3:0] modem_change;
   logic [`IRQ_N-1:0] masked;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // Parity bit for a given byte under the current mode
   function automatic logic parity_of(input logic [7:0] d, input uart_status_pkg::parity_mode_e m);
      logic p;
      p = 1'b0;
      unique case (m)
         uart_status_pkg::parity_even_sel: p = ^d;
         uart_status_pkg::parity_odd_sel: p = ~^d;
         uart_status_pkg::parity_stick_high: p = 1'b1;
         uart_status_pkg::parity_stick_low: p = 1'b0;
         default: p = 1'b0;
      endcase
      return p;
   endfunction : parity_of

   assign parity_mode = st_reg.parity;
   assign tx_parity_en = (st_reg.parity != uart_status_pkg::parity_off);
   assign tx_parity_bit = parity_of(tx_data, st_reg.parity);
   assign rx_parity_err = tx_parity_en &&
                          (rx_parity_in != parity_of(rx_data, st_reg.parity));

   assign masked = st_reg.raw & st_reg.enable;
   assign modem_change = st_reg.modem_in ^ st_reg.modem_prev;

   always_comb begin
      // Error flags: char-borne flags latch on a read character, overrun at once
      err_set = '0;
      err_set[`RXE_FRAMING] = rx_char_read && rx_char_framing;
      err_set[`RXE_PARITY] = rx_char_read && rx_char_parity;
      err_set[`RXE_BREAK] = rx_char_read && rx_char_break;
      err_set[`RXE_OVERRUN] = overrun_evt;
      irq_set = '0;
      irq_set[`IRQ_ADDR_MATCH] = addr_match_evt;
      irq_set[`IRQ_RX_TIMEOUT] = rx_timeout_evt;
      irq_set[`IRQ_TX] = tx_evt;
      irq_set[`IRQ_RX] = rx_evt;
      // Error interrupts fire only on a fresh flag rise, hence the re-arm order
      irq_set[`IRQ_FRAMING] = err_set[`RXE_FRAMING] && !st_reg.rx_err[`RXE_FRAMING];
      irq_set[`IRQ_PARITY] = err_set[`RXE_PARITY] && !st_reg.rx_err[`RXE_PARITY];
      irq_set[`IRQ_BREAK] = err_set[`RXE_BREAK] && !st_reg.rx_err[`RXE_BREAK];
      irq_set[`IRQ_OVERRUN] = err_set[`RXE_OVERRUN] && !st_reg.rx_err[`RXE_OVERRUN];
      irq_set[`IRQ_RI] = modem_change[`MIN_RI];
      irq_set[`IRQ_DCD] = modem_change[`MIN_DCD];
      irq_set[`IRQ_DSR] = modem_change[`MIN_DSR];
      irq_set[`IRQ_CTS] = modem_change[`MIN_CTS];
   end

   always_comb begin
      st_next = st_reg;
      // Two-stage synchroniser on modem pins; only stage two is looked at
      st_next.modem_meta = {cts_in, dsr_in, carrier_in, ring_in};
      st_next.modem_in = st_reg.modem_meta;
      st_next.modem_prev = st_reg.modem_in;
      if (req.wr) begin
         unique case (req.addr)
            `OFS_INT_ENABLE: st_next.enable = req.wdata[`IRQ_N-1:0];
            `OFS_INT_CLEAR: st_next.raw = st_reg.raw & ~req.wdata[`IRQ_N-1:0];
            `OFS_MODEM_SET: st_next.modem_out = st_reg.modem_out | req.wdata[1:0];
            `OFS_MODEM_CLR: st_next.modem_out = st_reg.modem_out & ~req.wdata[1:0];
            `OFS_PARITY: begin
               // Unknown codes are ignored so the mode is always legal
               if (req.wdata[2:0] <= 3'h4) begin
                  st_next.parity = uart_status_pkg::parity_mode_e'(req.wdata[2:0]);
               end
            end
            `OFS_RX_ERR_CLR: st_next.rx_err = '0;
            default: ;
         endcase
      end
      // Sets win over a same-cycle clear
      st_next.raw = st_next.raw | irq_set;
      st_next.rx_err = st_next.rx_err | err_set;
      st_next.irq = |(st_next.raw & st_next.enable);
      st_next.rdata = '0;
      if (req.rd) begin
         unique case (req.addr)
            `OFS_INT_RAW: st_next.rdata = 32'(st_reg.raw);
            `OFS_INT_MASKED: st_next.rdata = 32'(masked);
            `OFS_INT_ENABLE: st_next.rdata = 32'(st_reg.enable);
            `OFS_MODEM_OUT: st_next.rdata = 32'(st_reg.modem_out);
            `OFS_MODEM_IN: st_next.rdata = 32'(st_reg.modem_in);
            `OFS_PARITY: st_next.rdata = 32'(st_reg.parity);
            `OFS_RX_ERR: st_next.rdata = 32'(st_reg.rx_err);
            default: st_next.rdata = '0;
         endcase
      end
      if (srst) begin
         st_next = '0;
         st_next.enable = `RST_IRQ_EN;
         st_next.parity = uart_status_pkg::parity_mode_e'(`RST_PARITY);
      end
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   assign rdata = st_reg.rdata;
   assign irq = st_reg.irq;
   assign dtr_out = st_reg.modem_out[`MOUT_DTR];
   assign rts_out = st_reg.modem_out[`MOUT_RTS];

endmodule : uart_irq_modem_error_status

/* File: verification/uart_status_props.sv */
// Port assertions for the serial port status block.
// Bound to the block; one clock, synchronous reset.
`timescale 1ns/10ps
`include "uart_status_map.svh"
module status_props (
   // Bus
   input wire logic clk,
   input wire logic srst,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // Engine and pins
   input wire logic overrun_evt,
   input wire logic tx_parity_en,
   input wire logic tx_parity_bit,
   input wire logic rx_parity_in,
   input wire logic rx_parity_err,
   input wire uart_status_pkg::parity_mode_e parity_mode,
   input wire logic dtr_out,
   input wire logic rts_out,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // The bench reads two cycles after the overrun pulse, so allow one or two
   sequence ovr_rd;
      overrun_evt ##[1:2] (rd && addr == `OFS_RX_ERR);
   endsequence
   mask_off_a:
      assert property (wr && addr == `OFS_INT_ENABLE && wdata[11:0] == 12'h0 |=> !irq)
         else $error("irq with all sources masked");
   modem_set_a:
      assert property (wr && addr == `OFS_MODEM_SET |=> {rts_out, dtr_out} ==
         ({$past(rts_out), $past(dtr_out)} | $past(wdata[1:0]))) else $error("modem set");
   modem_clr_a:
      assert property (wr && addr == `OFS_MODEM_CLR |=> {rts_out, dtr_out} ==
         ({$past(rts_out), $past(dtr_out)} & ~$past(wdata[1:0]))) else $error("modem clear");
   out_view_a:
      assert property (rd && addr == `OFS_MODEM_OUT |=> rdata[1:0] ==
         {$past(rts_out), $past(dtr_out)}) else $error("modem out read");
   mode_write_a:
      assert property (wr && addr == `OFS_PARITY && wdata <= 32'h4 |=>
         parity_mode == $past(wdata[2:0])) else $error("parity mode write");
   parity_en_a:
      assert property (tx_parity_en == (parity_mode != uart_status_pkg::parity_off))
         else $error("parity enable");
   stick_parity_a:
      assert property (parity_mode inside {uart_status_pkg::parity_stick_high,
         uart_status_pkg::parity_stick_low} |-> rx_parity_err == (rx_parity_in != tx_parity_bit)
         && tx_parity_bit == (parity_mode == uart_status_pkg::parity_stick_high))
         else $error("stick parity");
   overrun_now_a:
      assert property (ovr_rd |=> rdata[3]) else $error("overrun flag late");
endmodule : status_props
bind uart_irq_modem_error_status status_props u_props (.clk, .srst, .addr, .wdata, .wr, .rd,
   .rdata, .overrun_evt, .tx_parity_en, .tx_parity_bit, .rx_parity_in, .rx_parity_err,
   .parity_mode, .dtr_out, .rts_out, .irq);

/* File: verification/modem_peer.sv */
// Modem peer: loops DTR to DSR and RTS to CTS, drives RI and DCD on request.
// Assumes the block's clock; pins move only just after a rising edge.
`timescale 1ns/10ps
module modem_peer (
   input wire logic clk,
   input wire logic dtr_out,
   input wire logic rts_out,
   input wire logic [1:0] line_req,
   output logic ring_in,
   output logic carrier_in,
   output logic dsr_in,
   output logic cts_in
);
   initial {carrier_in, ring_in, cts_in, dsr_in} = 4'h0;
   always @(posedge clk) begin
      {carrier_in, ring_in, cts_in, dsr_in} <= {line_req, rts_out, dtr_out};
   end
endmodule : modem_peer

/* File: verification/uart_irq_modem_error_status_tb.sv */
// Self-checking bench for the serial port status block.
// Assumes uart_status_map.svh on the include path and the modem peer on the pins.
`timescale 1ns/10ps
`include "uart_status_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module uart_irq_modem_error_status_tb;
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rx_parity_in = 1'b0;
   logic [3:0] addr = 4'h0, ch = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, r;
   logic [4:0] ev = 5'h0;
   logic [7:0] tx_data = 8'h0, rx_data = 8'h0;
   logic [1:0] lreq = 2'h0;
   logic [11:0] m;
   logic tx_parity_en, tx_parity_bit, rx_parity_err, dtr_out, rts_out, irq;
   logic ring_in, carrier_in, dsr_in, cts_in;
   uart_status_pkg::parity_mode_e parity_mode, pm;
   int failures = 0, checks = 0;
   always #10 clk = ~clk;
   uart_irq_modem_error_status DUT (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
      .addr_match_evt(ev[0]), .rx_timeout_evt(ev[1]), .tx_evt(ev[2]), .rx_evt(ev[3]),
      .overrun_evt(ev[4]), .rx_char_read(ch[0]), .rx_char_framing(ch[1]),
      .rx_char_parity(ch[2]), .rx_char_break(ch[3]), .tx_data, .tx_parity_en,
      .tx_parity_bit, .rx_data, .rx_parity_in, .rx_parity_err, .parity_mode, .ring_in,
      .carrier_in, .dsr_in, .cts_in, .dtr_out, .rts_out, .irq);
   modem_peer peer (.clk, .dtr_out, .rts_out, .line_req(lreq), .ring_in, .carrier_in,
      .dsr_in, .cts_in);
   function automatic logic exp_bit(uart_status_pkg::parity_mode_e md, logic [7:0] d);
      case (md)
         uart_status_pkg::parity_even_sel: return ^d;
         uart_status_pkg::parity_odd_sel: return ~^d;
         uart_status_pkg::parity_stick_high: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : exp_bit
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask : wreg
   task automatic rreg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk) {addr, rd} <= {a, 1'b1};
      @(posedge clk) rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   task automatic pulse(input logic [4:0] e, input logic [3:0] c);
      @(posedge clk) {ev, ch} <= {e, c};
      @(posedge clk) {ev, ch} <= 9'h0;
   endtask : pulse
   task automatic stop_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      stop_test();
   end
   initial begin
      void'($urandom(4902));
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 16; a++) begin
         rreg(a[3:0], r);
         `CHK("reset read", 32'h0, r)
      end
      // Mask zero first: raw must still show what masked hides
      for (int i = 0; i < 5; i++) begin
         m = (i == 0) ? 12'h0 : 12'($urandom);
         wreg(`OFS_INT_ENABLE, {20'h0, m});
         pulse(5'h0f, 4'h0);
         rreg(`OFS_INT_RAW, r);
         `CHK("raw", 32'h0e1, r)
         rreg(`OFS_INT_MASKED, r);
         `CHK("masked", {20'h0, m & 12'h0e1}, r)
         `CHK("irq", |(m & 12'h0e1), irq)
         wreg(`OFS_INT_ENABLE, 32'h0);
         `CHK("irq masked", 1'b0, irq)
         wreg(`OFS_INT_ENABLE, {20'h0, m});
         wreg(`OFS_INT_CLEAR, 32'h0e0);
         rreg(`OFS_INT_RAW, r);
         `CHK("raw cleared", 32'h001, r)
         wreg(`OFS_INT_CLEAR, 32'h001);
         `CHK("irq cleared", 1'b0, irq)
      end
      wreg(`OFS_MODEM_SET, 32'h1);
      `CHK("set dtr", 2'b01, {rts_out, dtr_out})
      wreg(`OFS_MODEM_SET, 32'h2);
      `CHK("set rts", 2'b11, {rts_out, dtr_out})
      wreg(`OFS_MODEM_CLR, 32'h1);
      rreg(`OFS_MODEM_OUT, r);
      `CHK("modem out", 32'h2, r)
      @(posedge clk) lreq <= 2'b11;
      // Covers the two-stage synchroniser plus the change detect
      repeat (6) @(posedge clk);
      rreg(`OFS_MODEM_IN, r);
      `CHK("modem in", 32'hb, r)
      rreg(`OFS_INT_RAW, r);
      `CHK("modem status", 32'hf00, r)
      for (int p = 0; p < 6; p++) begin
         wreg(`OFS_PARITY, 32'(p));
         pm = uart_status_pkg::parity_mode_e'((p < 5) ? p : 4);
         rreg(`OFS_PARITY, r);
         `CHK("mode", {29'h0, pm}, r)
         @(posedge clk) {tx_data, rx_data, rx_parity_in} <= 17'($urandom);
         @(posedge clk) #1;
         `CHK("tx parity", {pm != 0, pm != 0 && exp_bit(pm, tx_data)},
            {tx_parity_en, tx_parity_en && tx_parity_bit})
         `CHK("rx parity", pm != 0 && rx_parity_in != exp_bit(pm, rx_data),
            rx_parity_err)
      end
      wreg(`OFS_INT_CLEAR, 32'hfff);
      wreg(`OFS_INT_ENABLE, 32'h01e);
      pulse(5'h00, 4'h3);
      pulse(5'h10, 4'h0);
      rreg(`OFS_RX_ERR, r);
      `CHK("rx error", 32'h9, r)
      rreg(`OFS_INT_RAW, r);
      `CHK("error status", 32'h012, r)
      wreg(`OFS_INT_CLEAR, 32'hfff);
      pulse(5'h00, 4'h3);
      rreg(`OFS_INT_RAW, r);
      `CHK("not rearmed", 32'h0, r)
      wreg(`OFS_RX_ERR_CLR, 32'h0);
      rreg(`OFS_RX_ERR, r);
      `CHK("error clear", 32'h0, r)
      pulse(5'h00, 4'hd);
      rreg(`OFS_INT_RAW, r);
      `CHK("rearmed", 32'h00c, r)
      `CHK("error irq", 1'b1, irq)
      stop_test();
   end
endmodule : uart_irq_modem_error_status_tb
